// ### rtl/spd_defines.svh
// Constants of the split-port DDR burst SRAM pin core.
// Included by the array and pin modules; defines only.
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// ****************************************************************
// Organisation
// ****************************************************************
`define SPD_DATA_W 18
`define SPD_ADDR_W 21
`define SPD_LANE_W 9
`define SPD_BURST_IDX_W 2

// ****************************************************************
// Burst word positions
// ****************************************************************
`define SPD_WORD_0 2'h0
`define SPD_WORD_1 2'h1
`define SPD_WORD_2 2'h2
`define SPD_WORD_3 2'h3

// ****************************************************************
// Read latency in link half-cycles, token pipe depth
// ****************************************************************
`define SPD_LAT_LOOP_HE 5
`define SPD_LAT_LEGACY_HE 2
`define SPD_TOK_DEPTH 5

// ****************************************************************
// Termination strap capture
// ****************************************************************
`define SPD_STRAP_RESET 1'b1
`define SPD_STRAP_CAPTURE 2'h2
`define SPD_STRAP_LOCKED 2'h3

`endif

// ### rtl/spd_pkg.sv
// Types of the split-port DDR burst SRAM pin core.
// No dependencies.
package spd_pkg;

  // ****************************************************************
  // Write burst states
  // ****************************************************************
  typedef enum logic [3:0]
  {
    SPD_WR_IDLE = 4'h1,
    SPD_WR_W1 = 4'h2,
    SPD_WR_W2 = 4'h4,
    SPD_WR_W3 = 4'h8
  } spd_wr_state_e;

  // ****************************************************************
  // Read output states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    SPD_RD_IDLE = 3'h1,
    SPD_RD_DRIVE = 3'h2,
    SPD_RD_HOLD = 3'h4
  } spd_rd_state_e;

endpackage

// ### rtl/spd_array.sv
// Storage array with per-lane masked writes.
// Write is clocked on core_clk; read is asynchronous.
`timescale 1ns/100ps
`include "spd_defines.svh"
module spd_array
#(
  parameter int DATA_W = `SPD_DATA_W,
  parameter int IDX_W = `SPD_ADDR_W + `SPD_BURST_IDX_W
)
(
  input wire logic core_clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W/`SPD_LANE_W-1:0] wr_mask_n,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);
  localparam int LANES = DATA_W / `SPD_LANE_W;
  localparam int LW = `SPD_LANE_W;

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LW-1:0] lane_mem [0:(1<<IDX_W)-1];
      // Masked lane keeps its old contents
      always_ff @(posedge core_clk)
      begin
        if (ce && wr_en && !wr_mask_n[g])
        begin
          lane_mem[wr_idx] <= wr_data[g*LW +: LW];
        end
      end
      assign rd_data[g*LW +: LW] = lane_mem[rd_idx];
    end
  endgenerate

endmodule

// ### rtl/spd_pins.sv
// Pin-level core of a split-port DDR four-word burst SRAM.
// Assumes every pin except ce, k and k_n included, is asynchronous to core_clk
// and at least four core cycles between link half-edges.
`timescale 1ns/100ps
`include "spd_defines.svh"
module spd_pins
#(
  parameter int DATA_W = `SPD_DATA_W,
  parameter int ADDR_W = `SPD_ADDR_W
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic k,
  input wire logic k_n,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/`SPD_LANE_W-1:0] byte_write_mask_n,
  input wire logic clock_loop_off_n,
  input wire logic termination_range_strap,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_oe,
  output logic output_valid_flag,
  output logic echo_timing_output,
  output logic echo_timing_output_n,
  output logic term_range_high
);
  import spd_pkg::*;

  localparam int LANES = DATA_W / `SPD_LANE_W;
  localparam int IDX_W = ADDR_W + `SPD_BURST_IDX_W;
  localparam int TOK_D = `SPD_TOK_DEPTH;

  // ****************************************************************
  // Pin synchronisers and edge detect
  // ****************************************************************
  logic k_s1, k_s2, k_s3, kn_s1, kn_s2, kn_s3;
  logic wps_s1, wps_s2, rps_s1, rps_s2;
  logic clock_loop_off_n_s1, clock_loop_off_n_s2, strap_s1, strap_s2;
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DATA_W-1:0] d_s1, d_s2;
  logic [LANES-1:0] m_s1, m_s2;
  logic k_rise, kn_rise, half, loop_on;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {k_s1, k_s2, k_s3, kn_s1, kn_s2, kn_s3} <= 6'h00;
      {wps_s1, wps_s2, rps_s1, rps_s2} <= 4'hF;
      {clock_loop_off_n_s1, clock_loop_off_n_s2} <= 2'h3;
      {strap_s1, strap_s2} <= {2{`SPD_STRAP_RESET}};
      addr_s1 <= '0;
      addr_s2 <= '0;
      d_s1 <= '0;
      d_s2 <= '0;
      m_s1 <= '1;
      m_s2 <= '1;
    end
    else if (ce)
    begin
      k_s1 <= k;
      k_s2 <= k_s1;
      k_s3 <= k_s2;
      kn_s1 <= k_n;
      kn_s2 <= kn_s1;
      kn_s3 <= kn_s2;
      wps_s1 <= write_port_select_n;
      wps_s2 <= wps_s1;
      rps_s1 <= read_port_select_n;
      rps_s2 <= rps_s1;
      clock_loop_off_n_s1 <= clock_loop_off_n;
      clock_loop_off_n_s2 <= clock_loop_off_n_s1;
      strap_s1 <= termination_range_strap;
      strap_s2 <= strap_s1;
      addr_s1 <= addr;
      addr_s2 <= addr_s1;
      d_s1 <= wdata;
      d_s2 <= d_s1;
      m_s1 <= byte_write_mask_n;
      m_s2 <= m_s1;
    end
  end

  assign k_rise = ce & k_s2 & ~k_s3;
  assign kn_rise = ce & kn_s2 & ~kn_s3;
  assign half = k_rise | kn_rise;
  assign loop_on = clock_loop_off_n_s2;

  // Array index of one burst word
  function automatic logic [IDX_W-1:0] spd_idx(
    input logic [ADDR_W-1:0] a,
    input logic [`SPD_BURST_IDX_W-1:0] w
  );
    spd_idx = {a, w};
  endfunction

  // ****************************************************************
  // Write port
  // ****************************************************************
  spd_wr_state_e wr_state_r, wr_state_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [ADDR_W-1:0] wr_pend_addr_r, wr_pend_addr_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic mem_we;
  logic [IDX_W-1:0] mem_widx;

  always_comb
  begin
    wr_state_nxt = wr_state_r;
    wr_addr_nxt = wr_addr_r;
    wr_pend_nxt = wr_pend_r;
    wr_pend_addr_nxt = wr_pend_addr_r;
    mem_we = 1'b0;
    mem_widx = spd_idx(wr_addr_r, `SPD_WORD_0);
    if (k_rise)
    begin
      wr_pend_nxt = !wps_s2;
      if (!wps_s2)
      begin
        wr_pend_addr_nxt = addr_s2;
      end
      // Running burst wins; overlapping request is dropped
      if (wr_state_r == SPD_WR_W2)
      begin
        mem_we = 1'b1;
        mem_widx = spd_idx(wr_addr_r, `SPD_WORD_2);
        wr_state_nxt = SPD_WR_W3;
      end
      else if (wr_pend_r)
      begin
        mem_we = 1'b1;
        mem_widx = spd_idx(wr_pend_addr_r, `SPD_WORD_0);
        wr_addr_nxt = wr_pend_addr_r;
        wr_state_nxt = SPD_WR_W1;
      end
    end
    else if (kn_rise)
    begin
      unique case (wr_state_r)
        SPD_WR_W1:
        begin
          mem_we = 1'b1;
          mem_widx = spd_idx(wr_addr_r, `SPD_WORD_1);
          wr_state_nxt = SPD_WR_W2;
        end
        SPD_WR_W3:
        begin
          mem_we = 1'b1;
          mem_widx = spd_idx(wr_addr_r, `SPD_WORD_3);
          wr_state_nxt = SPD_WR_IDLE;
        end
        SPD_WR_IDLE, SPD_WR_W2:
        begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_state_r <= SPD_WR_IDLE;
      wr_addr_r <= '0;
      wr_pend_r <= 1'b0;
      wr_pend_addr_r <= '0;
    end
    else if (ce)
    begin
      wr_state_r <= wr_state_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_pend_addr_r <= wr_pend_addr_nxt;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [IDX_W-1:0] mem_ridx;
  logic [DATA_W-1:0] mem_rdata;

  spd_array #(.DATA_W(DATA_W), .IDX_W(IDX_W)) u_array
  (
    .core_clk(core_clk),
    .ce(ce),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_data(d_s2),
    .wr_mask_n(m_s2),
    .rd_idx(mem_ridx),
    .rd_data(mem_rdata)
  );

  // ****************************************************************
  // Read port and outputs
  // ****************************************************************
  spd_rd_state_e rd_state_r, rd_state_nxt;
  logic [TOK_D-1:0] tok_v_r, tok_v_nxt;
  logic [ADDR_W-1:0] tok_a_r [TOK_D];
  logic [ADDR_W-1:0] tok_a_nxt [TOK_D];
  logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt, launch_a;
  logic [`SPD_BURST_IDX_W-1:0] rd_cnt_r, rd_cnt_nxt;
  logic [DATA_W-1:0] q_r, q_nxt;
  logic oe_r, oe_nxt, vld_r, vld_nxt;
  logic echo_r, echo_n_r, term_r, term_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic launch;

  always_comb
  begin
    launch = half && (loop_on ? tok_v_r[`SPD_LAT_LOOP_HE-1]
                              : tok_v_r[`SPD_LAT_LEGACY_HE-1]);
    launch_a = loop_on ? tok_a_r[`SPD_LAT_LOOP_HE-1]
                       : tok_a_r[`SPD_LAT_LEGACY_HE-1];
    mem_ridx = launch ? spd_idx(launch_a, `SPD_WORD_0)
                      : spd_idx(rd_addr_r, rd_cnt_r);
    tok_v_nxt = tok_v_r;
    tok_a_nxt = tok_a_r;
    if (half)
    begin
      tok_v_nxt = {tok_v_r[TOK_D-2:0], k_rise & !rps_s2};
      tok_a_nxt[0] = (k_rise && !rps_s2) ? addr_s2 : '0;
      for (int i = 1; i < TOK_D; i++)
      begin
        tok_a_nxt[i] = tok_a_r[i-1];
      end
    end
    rd_state_nxt = rd_state_r;
    rd_addr_nxt = rd_addr_r;
    rd_cnt_nxt = rd_cnt_r;
    q_nxt = q_r;
    oe_nxt = oe_r;
    vld_nxt = vld_r;
    if (launch && rd_state_r != SPD_RD_DRIVE
        || launch && rd_cnt_r == `SPD_WORD_0)
    begin
      q_nxt = mem_rdata;
      oe_nxt = 1'b1;
      vld_nxt = 1'b1;
      rd_addr_nxt = launch_a;
      rd_cnt_nxt = `SPD_WORD_1;
      rd_state_nxt = SPD_RD_DRIVE;
    end
    else
    begin
      unique case (rd_state_r)
        SPD_RD_DRIVE:
        begin
          if (half && rd_cnt_r != `SPD_WORD_0)
          begin
            q_nxt = mem_rdata;
            rd_cnt_nxt = rd_cnt_r + 2'h1;
          end
          else if (half)
          begin
            vld_nxt = 1'b0;
            oe_nxt = !k_rise;
            rd_state_nxt = k_rise ? SPD_RD_IDLE : SPD_RD_HOLD;
          end
        end
        SPD_RD_HOLD:
        begin
          if (k_rise)
          begin
            oe_nxt = 1'b0;
            rd_state_nxt = SPD_RD_IDLE;
          end
        end
        SPD_RD_IDLE:
        begin
          oe_nxt = 1'b0;
        end
      endcase
    end
    strap_cnt_nxt = strap_cnt_r;
    term_nxt = term_r;
    if (strap_cnt_r != `SPD_STRAP_LOCKED)
    begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
    end
    if (strap_cnt_r == `SPD_STRAP_CAPTURE)
    begin
      term_nxt = strap_s2;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_state_r <= SPD_RD_IDLE;
      tok_v_r <= '0;
      for (int i = 0; i < TOK_D; i++)
      begin
        tok_a_r[i] <= '0;
      end
      rd_addr_r <= '0;
      rd_cnt_r <= `SPD_WORD_0;
      q_r <= '0;
      oe_r <= 1'b0;
      vld_r <= 1'b0;
      echo_r <= 1'b0;
      echo_n_r <= 1'b0;
      term_r <= `SPD_STRAP_RESET;
      strap_cnt_r <= 2'h0;
    end
    else if (ce)
    begin
      rd_state_r <= rd_state_nxt;
      tok_v_r <= tok_v_nxt;
      tok_a_r <= tok_a_nxt;
      rd_addr_r <= rd_addr_nxt;
      rd_cnt_r <= rd_cnt_nxt;
      q_r <= q_nxt;
      oe_r <= oe_nxt;
      vld_r <= vld_nxt;
      echo_r <= k_s2;
      echo_n_r <= kn_s2;
      term_r <= term_nxt;
      strap_cnt_r <= strap_cnt_nxt;
    end
  end

  assign rdata = q_r;
  assign rdata_oe = oe_r;
  assign output_valid_flag = vld_r;
  assign echo_timing_output = echo_r;
  assign echo_timing_output_n = echo_n_r;
  assign term_range_high = term_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [1:0] he_mod_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      he_mod_r <= 2'h0;
    end
    else if (ce)
    begin
      he_mod_r <= !vld_r ? 2'h0 : (half ? he_mod_r + 2'h1 : he_mod_r);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_wr_edge_only: assert property (mem_we |-> half && ce)
    else $error("write outside a link edge");
  chk_wr_idle_skip: assert property (
    (k_rise && wr_state_r != SPD_WR_W2 && !wr_pend_r) |-> !mem_we)
    else $error("write with port deselected");
  chk_wr_addr_hold: assert property (
    (wr_state_r != SPD_WR_IDLE && $past(wr_state_r) != SPD_WR_IDLE)
    |-> $stable(wr_addr_r))
    else $error("write address moved inside a burst");
  chk_burst_four: assert property ($fell(vld_r) |-> he_mod_r == 2'h0)
    else $error("read burst not a multiple of four words");
  chk_vld_launch: assert property (launch |=> vld_r && oe_r)
    else $error("valid or enable missing at read launch");
  chk_float_k_edge: assert property ($fell(oe_r) |-> $past(k_rise))
    else $error("outputs floated off a k rise");
  chk_float_no_vld: assert property (!oe_r |-> !vld_r)
    else $error("valid flag while outputs float");
  chk_lat_loop: assert property (
    ($rose(vld_r) && loop_on) |-> $past(kn_rise))
    else $error("loop mode burst not on k_n rise");
  chk_lat_legacy: assert property (
    ($rose(vld_r) && !loop_on) |-> $past(k_rise))
    else $error("legacy burst not on k rise");
  chk_echo_follow: assert property (k_rise |=> $rose(echo_r))
    else $error("echo clock did not follow k");
  chk_strap_lock: assert property (
    (strap_cnt_r == `SPD_STRAP_LOCKED) |=> $stable(term_r))
    else $error("termination range changed after capture");

  cov_read_loop: cover property ($rose(vld_r) && loop_on);
  cov_read_legacy: cover property ($rose(vld_r) && !loop_on);
  cov_write_masked: cover property (mem_we && m_s2 != '1 && m_s2 != '0);
  cov_read_back2back: cover property (launch && rd_state_r == SPD_RD_DRIVE);

endmodule

// ### sim/spd_ctl_model.sv
// Controller model: link clocks, selects, shared address, write bursts.
// Assumes eight core cycles per link period; requests queued by tasks.
`timescale 1ns/100ps
module spd_ctl_model
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6
)
(
  input wire logic core_clk,
  input wire logic nrst,
  output logic k,
  output logic k_n,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  output logic [DATA_W/9-1:0] byte_write_mask_n,
  output logic rd_issue
);
  localparam int LN = DATA_W / 9;
  logic [2:0] ph;
  logic [2:0] hs;
  logic [DATA_W-1:0] sd [8];
  logic [LN-1:0] sm [8];
  bit sv [8];
  logic [ADDR_W-1:0] rq [$];
  logic [ADDR_W-1:0] wq [$];
  logic [4*DATA_W-1:0] wd [$];
  logic [4*LN-1:0] wm [$];
  logic [4*DATA_W-1:0] d;
  logic [4*LN-1:0] m;
  int rgap;
  int wgap;

  task automatic put_write(input logic [ADDR_W-1:0] a,
    input logic [4*DATA_W-1:0] dd, input logic [4*LN-1:0] mm);
    wq.push_back(a);
    wd.push_back(dd);
    wm.push_back(mm);
  endtask

  task automatic put_read(input logic [ADDR_W-1:0] a);
    rq.push_back(a);
  endtask

  function automatic bit busy();
    return (rq.size() + wq.size()) != 0;
  endfunction

  // ****************************************************************
  // Clocks, selects and data slots
  // ****************************************************************
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph <= 3'h0;
      hs <= 3'h0;
      k <= 1'b0;
      k_n <= 1'b0;
      write_port_select_n <= 1'b1;
      read_port_select_n <= 1'b1;
      addr <= '0;
      wdata <= '0;
      byte_write_mask_n <= '1;
      rd_issue <= 1'b0;
      rgap = 0;
      wgap = 0;
      for (int i = 0; i < 8; i++)
        sv[i] = 1'b0;
    end
    else
    begin
      ph <= ph + 3'h1;
      k <= (ph == 3'h7) || (ph < 3'h3);
      k_n <= (ph > 3'h2) && (ph != 3'h7);
      rd_issue <= 1'b0;
      if (ph == 3'h2)
      begin
        // Released lines show the inverse, never a stale value
        read_port_select_n <= 1'b1;
        write_port_select_n <= 1'b1;
        addr <= ~addr;
      end
      if (ph == 3'h1 || ph == 3'h5)
      begin
        hs <= hs + 3'h1;
        wdata <= sv[hs] ? sd[hs] : ~wdata;
        byte_write_mask_n <= sv[hs] ? sm[hs] : ~byte_write_mask_n;
        sv[hs] = 1'b0;
      end
      if (ph == 3'h5)
      begin
        rgap = rgap - int'(rgap != 0);
        wgap = wgap - int'(wgap != 0);
        if (rgap == 0 && rq.size() != 0)
        begin
          read_port_select_n <= 1'b0;
          addr <= rq.pop_front();
          rd_issue <= 1'b1;
          rgap = 2;
        end
        else if (wgap == 0 && wq.size() != 0)
        begin
          write_port_select_n <= 1'b0;
          addr <= wq.pop_front();
          d = wd.pop_front();
          m = wm.pop_front();
          wgap = 2;
          for (int i = 0; i < 4; i++)
          begin
            sd[(hs + i + 2) % 8] = d[i*DATA_W +: DATA_W];
            sm[(hs + i + 2) % 8] = m[i*LN +: LN];
            sv[(hs + i + 2) % 8] = 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench of the split-port burst SRAM pin core.
// Assumes spd_pins and spd_ctl_model; memory model kept in the bench.
`timescale 1ns/100ps
module tb_top;
  localparam int DW = 18;
  localparam int AW = 6;
  localparam int LN = DW / 9;
  logic core_clk, nrst, ce, clock_loop_off_n, termination_range_strap;
  logic k, k_n, write_port_select_n, read_port_select_n, rd_issue;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [LN-1:0] byte_write_mask_n;
  logic rdata_oe, output_valid_flag, term_range_high;
  logic echo_timing_output, echo_timing_output_n, pe, pen;
  int num_errors, check_count, seed, lat, ec, wi, n;
  bit armed;
  logic [DW-1:0] mem [int];
  logic [DW-1:0] exp_q [$];
  int req_q [$];

  spd_pins #(.DATA_W(DW), .ADDR_W(AW)) uut (.core_clk, .nrst, .ce, .k,
    .k_n, .write_port_select_n, .read_port_select_n, .addr, .wdata,
    .byte_write_mask_n, .clock_loop_off_n, .termination_range_strap,
    .rdata, .rdata_oe, .output_valid_flag, .echo_timing_output,
    .echo_timing_output_n, .term_range_high);

  spd_ctl_model #(.DATA_W(DW), .ADDR_W(AW)) u_ctl (.core_clk, .nrst, .k,
    .k_n, .write_port_select_n, .read_port_select_n, .addr, .wdata,
    .byte_write_mask_n, .rd_issue);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Checks and tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] want,
    input string what);
    check_count++;
    if (seen !== want)
    begin
      $display("mismatch %s expected %0h seen %0h", what, want, seen);
      num_errors++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input int a, input bit full);
    logic [4*DW-1:0] d;
    logic [4*LN-1:0] m;
    for (int w = 0; w < 4; w++)
    begin
      d[w*DW +: DW] = DW'($random(seed));
      m[w*LN +: LN] = full ? '0 : LN'($random(seed));
      for (int l = 0; l < LN; l++)
        if (!m[w*LN + l])
          mem[a * 4 + w][l*9 +: 9] = d[w*DW + l*9 +: 9];
    end
    u_ctl.put_write(AW'(a), d, m);
  endtask

  task automatic rd(input int a);
    for (int w = 0; w < 4; w++)
      exp_q.push_back(mem[a * 4 + w]);
    u_ctl.put_read(AW'(a));
  endtask

  task automatic drain();
    int t;
    t = 0;
    while ((exp_q.size() != 0 || u_ctl.busy()) && t < 3000)
    begin
      @(posedge core_clk);
      t++;
    end
    chk(t < 3000, 1, "drain");
    repeat (24) @(posedge core_clk);
    chk(rdata_oe, 0, "rdata_oe idle");
    chk(output_valid_flag, 0, "valid idle");
  endtask

  task automatic do_reset(input logic s);
    @(posedge core_clk);
    nrst <= 1'b0;
    termination_range_strap <= s;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(term_range_high, s, "term_range_high");
  endtask

  task automatic take_word();
    if (wi == 0)
      chk(ec - (req_q.size() ? req_q.pop_front() : 0), lat, "latency");
    chk(exp_q.size() != 0, 1, "word expected");
    chk(rdata, exp_q.size() ? exp_q.pop_front() : ~rdata, "rdata");
    chk(rdata_oe, 1, "rdata_oe");
    wi = (wi + 1) % 4;
  endtask

  // ****************************************************************
  // Output monitor on echo rises
  // ****************************************************************
  always @(negedge core_clk)
  begin
    if (!nrst)
    begin
      wi = 0;
      armed = 1'b0;
      req_q.delete();
      pe = 1'b0;
      pen = 1'b0;
    end
    else
    begin
      if (rd_issue)
        armed = 1'b1;
      if ((echo_timing_output && !pe) || (echo_timing_output_n && !pen))
      begin
        ec++;
        if (armed && echo_timing_output && !pe)
        begin
          req_q.push_back(ec);
          armed = 1'b0;
        end
        if (output_valid_flag === 1'b1)
          take_word();
      end
      pe = echo_timing_output;
      pen = echo_timing_output_n;
    end
  end

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    seed = 7184;
    nrst = 1'b0;
    ce = 1'b1;
    clock_loop_off_n = 1'b1;
    termination_range_strap = 1'b0;
    num_errors = 0;
    check_count = 0;
    lat = 5;
    ec = 0;
    do_reset(1'b0);
    for (int i = 0; i < 8; i++)
      wr(i, 1'b1);
    for (int i = 0; i < 8; i++)
      wr(i, 1'b0);
    drain();
    for (int i = 0; i < 8; i++)
    begin
      rd(i);
      wr(i + 8, 1'b1);
    end
    drain();
    n = ec;
    repeat (40) @(posedge core_clk);
    chk(ec - n, 10, "echo rises");
    ce <= 1'b0;
    repeat (2) @(posedge core_clk);
    n = ec;
    repeat (40) @(posedge core_clk);
    chk(ec - n, 0, "echo frozen");
    ce <= 1'b1;
    repeat (8) @(posedge core_clk);
    clock_loop_off_n <= 1'b0;
    lat = 2;
    for (int i = 0; i < 16; i++)
      rd(i);
    drain();
    do_reset(1'b1);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
endmodule
